// [event_timer_pkg.sv]
package event_timer_pkg;
   // Register word addresses on the plain register port.
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] mode_offset = 8'h04;
   localparam logic [7:0] trigger_offset = 8'h08;
   localparam logic [7:0] data_offset = 8'h0C;
   localparam logic [7:0] count_offset = 8'h10;
   localparam logic [7:0] status_offset = 8'h14;
   // Control register fields.
   localparam int unit_enable_pos = 0;
   localparam int filter_enable_pos = 1;
   localparam int output_enable_pos = 2;
   // Mode register fields.
   localparam int mode_capture_pos = 0;
   localparam int start_int_pos = 1;
   localparam int edge_sel_lsb = 2;
   localparam int trig_src_lsb = 4;
   localparam int clock_sel_lsb = 8;
   // Trigger register fields.
   localparam int start_trig_pos = 0;
   localparam int stop_trig_pos = 1;
   // Status register fields.
   localparam int overflow_pos = 0;
   localparam int enable_status_pos = 1;
   // Reset values and the count limit.
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [15:0] data_reset = 16'h0000;
   localparam logic [15:0] count_max = 16'hFFFF;
   localparam logic [11:0] mode_reset = 12'h000;
   // Edge select encodings.
   localparam logic [1:0] edge_falling = 2'h0;
   localparam logic [1:0] edge_rising = 2'h1;
endpackage

// [timer_link_if.sv]
`timescale 1ns/1ps
// Signals shared between the channel core and its helper modules.
interface timer_link_if;
   logic clear;
   logic filter_enable;
   logic [1:0] edge_sel;
   logic edge_event;
   logic [3:0] clock_sel;
   logic count_tick;
   modport conditioner (input clear, input filter_enable, input edge_sel, output edge_event);
   modport prescaler (input clear, input clock_sel, output count_tick);
   modport core (output clear, output filter_enable, output edge_sel, input edge_event,
      output clock_sel, input count_tick);
endinterface

// [input_conditioner.sv]
`timescale 1ns/1ps
module input_conditioner
   import event_timer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_timer_input_pin,
   timer_link_if.conditioner link
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic level;
      logic event_out;
   } cond_state_type;

   cond_state_type state_reg;
   cond_state_type state_next;

   // Synchronise, optionally filter, then detect the selected edge.
   always_comb begin
      state_next = state_reg;
      // Pin sampled on the operating clock.
      state_next.sync1 = i_timer_input_pin;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      if (!link.filter_enable || state_reg.sync2 == state_reg.sync3) begin
         state_next.level = state_reg.sync2;
      end
      case (link.edge_sel)
         edge_falling: state_next.event_out = state_reg.level & ~state_next.level;
         edge_rising: state_next.event_out = ~state_reg.level & state_next.level;
         default: state_next.event_out = state_reg.level ^ state_next.level;
      endcase
      if (link.clear) begin
         state_next = '0;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= '0;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign link.edge_event = state_reg.event_out;
endmodule

// [count_prescaler.sv]
`timescale 1ns/1ps
module count_prescaler
   import event_timer_pkg::*;
#(
   parameter int width = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   timer_link_if.prescaler link
);
   typedef struct packed {
      logic [width-1:0] div;
      logic tick;
   } presc_state_type;

   presc_state_type state_reg;
   presc_state_type state_next;
   logic [width-1:0] mask;

   // Tick once every two to the power of the selected divide.
   always_comb begin
      state_next = state_reg;
      mask = (width'(1) << link.clock_sel) - width'(1);
      state_next.div = state_reg.div + width'(1);
      state_next.tick = ((state_reg.div & mask) == mask);
      if (link.clear) begin
         state_next = '0;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= '0;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign link.count_tick = state_reg.tick;
endmodule

// [event_count_pulse_interval_timer.sv]
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module event_count_pulse_interval_timer
   import event_timer_pkg::*;
#(
   parameter int count_width = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_timer_input_pin,
   output logic [31:0] o_rdata,
   output logic o_channel_interrupt,
   output logic o_timer_output_pin
);
   typedef struct packed {
      logic unit_enable;
      logic filter_enable;
      logic output_enable;
      logic [11:0] mode;
      logic [count_width-1:0] data;
      logic [count_width-1:0] count;
      logic overflow_flag;
      logic overflow_pending;
      logic enable_status;
      logic clear_pending;
      logic irq;
      logic out_level;
      logic [31:0] rdata;
   } core_state_type;

   core_state_type state_reg;
   core_state_type state_next;
   logic wr_ctrl;
   logic wr_en;
   logic start_trig;
   logic stop_trig;
   logic capture_mode;

   timer_link_if link();

   input_conditioner u_cond (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_timer_input_pin(i_timer_input_pin),
      .link(link)
   );

   count_prescaler u_presc (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .link(link)
   );

   // Steering toward the helper modules; a disabled unit holds them clear.
   assign link.clear = ~state_reg.unit_enable;
   assign link.filter_enable = state_reg.filter_enable;
   assign link.edge_sel = state_reg.mode[edge_sel_lsb +: 2];
   assign link.clock_sel = state_reg.mode[clock_sel_lsb +: 4];

   // Writes other than control ignored when disabled.
   assign wr_ctrl = i_wr && i_addr == ctrl_offset;
   assign wr_en = i_wr && state_reg.unit_enable;
   assign start_trig = wr_en && i_addr == trigger_offset && i_wdata[start_trig_pos];
   assign stop_trig = wr_en && i_addr == trigger_offset && i_wdata[stop_trig_pos];
   assign capture_mode = state_reg.mode[mode_capture_pos];

   // Next-state logic for registers, counting and capture.
   always_comb begin
      state_next = state_reg;
      state_next.irq = 1'b0;
      if (wr_ctrl) begin
         state_next.unit_enable = i_wdata[unit_enable_pos];
         if (state_reg.unit_enable) begin
            state_next.filter_enable = i_wdata[filter_enable_pos];
            state_next.output_enable = i_wdata[output_enable_pos];
         end
      end
      if (wr_en && i_addr == mode_offset) begin
         state_next.mode = i_wdata[11:0];
      end
      // Data may be written at any time while the unit is enabled.
      if (wr_en && i_addr == data_offset) begin
         state_next.data = i_wdata[count_width-1:0];
      end
      if (!capture_mode) begin
         if (start_trig) begin
            state_next.count = state_next.data;
            state_next.enable_status = 1'b1;
            if (state_reg.mode[start_int_pos]) begin
               state_next.irq = 1'b1;
            end
         end else if (state_reg.enable_status && link.edge_event) begin
            if (state_reg.count == count_width'(0)) begin
               state_next.count = state_next.data;
               // Fires after data plus one edges.
               state_next.irq = 1'b1;
            end else begin
               state_next.count = state_reg.count - count_width'(1);
            end
         end
      end else begin
         if (start_trig && !state_reg.enable_status) begin
            state_next.enable_status = 1'b1;
            state_next.clear_pending = 1'b1;
            state_next.overflow_pending = 1'b0;
            state_next.irq = state_reg.mode[start_int_pos];
         end else if (state_reg.enable_status &&
               (link.edge_event || start_trig)) begin
            // Software start acts as capture edge.
            // Captured value plus flag give interval.
            state_next.data = state_reg.count;
            state_next.count = count_width'(0);
            state_next.irq = 1'b1;
            state_next.clear_pending = 1'b0;
            state_next.overflow_flag = state_reg.overflow_pending;
            state_next.overflow_pending = 1'b0;
         end else if (state_reg.enable_status && link.count_tick) begin
            if (state_reg.clear_pending) begin
               state_next.count = count_width'(0);
               state_next.clear_pending = 1'b0;
            end else begin
               state_next.count = state_reg.count + count_width'(1);
               if (state_reg.count == count_max[count_width-1:0]) begin
                  state_next.overflow_pending = 1'b1;
               end
            end
         end
      end
      // Stop halts, count and flag hold.
      if (stop_trig) begin
         state_next.enable_status = 1'b0;
         state_next.clear_pending = 1'b0;
         state_next.irq = 1'b0;
      end
      // Output pin toggles on every interrupt when enabled.
      if (state_next.irq && state_reg.output_enable) begin
         state_next.out_level = ~state_reg.out_level;
      end
      // Read data stand in the cycle after the strobe only.
      state_next.rdata = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            ctrl_offset: begin
               state_next.rdata[unit_enable_pos] = state_reg.unit_enable;
               state_next.rdata[filter_enable_pos] = state_reg.filter_enable;
               state_next.rdata[output_enable_pos] = state_reg.output_enable;
            end
            mode_offset: state_next.rdata[11:0] = state_reg.mode;
            data_offset: state_next.rdata[count_width-1:0] = state_reg.data;
            count_offset: state_next.rdata[count_width-1:0] = state_reg.count;
            status_offset: begin
               state_next.rdata[overflow_pos] = state_reg.overflow_flag;
               state_next.rdata[enable_status_pos] = state_reg.enable_status;
            end
            default: state_next.rdata = 32'h0000_0000;
         endcase
      end
      if (!state_next.unit_enable) begin
         state_next = '0;
         state_next.rdata = state_reg.unit_enable ? 32'h0000_0000 : state_next.rdata;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= '0;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign o_rdata = state_reg.rdata;
   assign o_channel_interrupt = state_reg.irq;
   assign o_timer_output_pin = state_reg.out_level;
endmodule

// [pulse_source.sv]
`timescale 1ns/1ps
// Sends bursts of whole pulses, each level held four cycles; the pin idles low.
module pulse_source (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_req,
   input wire logic [7:0] i_pulses,
   output logic o_pin,
   output logic o_busy
);
   logic [10:0] left_reg;
   // Counts down eight clocks per pulse.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         left_reg <= 11'h000;
      end else if (i_req) begin
         left_reg <= {i_pulses, 3'h0};
      end else if (left_reg != 11'h000) begin
         left_reg <= left_reg - 11'h001;
      end
   end
   assign o_pin = left_reg[2];
   assign o_busy = (left_reg != 11'h000);
endmodule

// [event_count_pulse_interval_timer_sva.sv]
`timescale 1ns/1ps
// Watches the register port and the interrupt of the timer channel.
module timer_checker
   import event_timer_pkg::*;
#(
   parameter int count_width = 16
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_timer_input_pin,
   input wire logic [31:0] o_rdata,
   input wire logic o_channel_interrupt,
   input wire logic o_timer_output_pin
);
   logic en_reg;
   logic cap_reg;
   logic [15:0] data_reg;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset || !i_ce);
   // Mirrors unit enable, the mode capture bit and the last data value written.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         en_reg <= 1'b0;
         cap_reg <= 1'b0;
         data_reg <= data_reset;
      end else if (i_wr && i_ce) begin
         if (i_addr == ctrl_offset) en_reg <= i_wdata[unit_enable_pos];
         if (i_addr == ctrl_offset && !i_wdata[unit_enable_pos]) begin
            cap_reg <= 1'b0;
            data_reg <= data_reset;
         end
         if (en_reg && i_addr == mode_offset) cap_reg <= i_wdata[mode_capture_pos];
         if (en_reg && i_addr == data_offset) data_reg <= i_wdata[15:0];
      end
   end
   a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   a_trig_reads_zero: assert property (
      i_rd && i_addr == trigger_offset |=> o_rdata == 32'h0000_0000)
      else $error("trigger register did not read zero");
   a_disabled_reads: assert property (
      i_rd && !en_reg && i_addr != ctrl_offset |=> o_rdata == 32'h0000_0000)
      else $error("register not cleared while unit disabled");
   a_data_readback: assert property (
      i_rd && i_addr == data_offset && !cap_reg |=> o_rdata == {16'h0000, data_reg})
      else $error("data register lost a written value");
   a_status_width: assert property (
      i_rd && i_addr == status_offset |=> o_rdata[31:2] == 30'h0000_0000)
      else $error("status read has stray bits");
   a_count_width: assert property (
      i_rd && i_addr == count_offset |=> o_rdata[31:16] == 16'h0000)
      else $error("count read wider than sixteen bits");
   a_no_irq_off: assert property (
      !en_reg && !$past(en_reg) |-> !o_channel_interrupt)
      else $error("interrupt while unit disabled");
   a_stop_quiet: assert property (
      i_wr && i_addr == trigger_offset && i_wdata[1:0] == 2'h2 |=> !o_channel_interrupt)
      else $error("interrupt right after stop");
endmodule
bind event_count_pulse_interval_timer timer_checker #(.count_width(count_width)) i_timer_checker (
   .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_timer_input_pin(i_timer_input_pin), .o_rdata(o_rdata),
   .o_channel_interrupt(o_channel_interrupt), .o_timer_output_pin(o_timer_output_pin));

// [testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the event counter and interval capture channel.
module testbench;
   import event_timer_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset, i_wr, i_rd, req, pin, busy, irq, tout;
   logic [7:0] i_addr, npulse;
   logic [31:0] i_wdata, o_rdata;
   int miscompares = 0;
   int tests_run = 0;
   int irqs = 0;
   event_count_pulse_interval_timer i_event_count_pulse_interval_timer (.i_clk(i_clk),
      .i_reset(i_reset), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .i_timer_input_pin(pin), .o_rdata(o_rdata), .o_channel_interrupt(irq),
      .o_timer_output_pin(tout));
   pulse_source i_pulse_source (.i_clk(i_clk), .i_reset(i_reset), .i_req(req),
      .i_pulses(npulse), .o_pin(pin), .o_busy(busy));
   // Clock and interrupt tally.
   initial begin
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) if (irq === 1'b1) irqs <= irqs + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
      @(posedge i_clk);
   endtask
   // Sends n pulses and lets the input pipeline drain.
   task automatic pulses(input logic [7:0] n);
      int k;
      npulse <= n;
      req <= 1'b1;
      @(posedge i_clk);
      req <= 1'b0;
      @(negedge i_clk);
      for (k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge i_clk);
      if (busy !== 1'b0) begin
         miscompares++;
         conclude();
      end
      repeat (8) @(posedge i_clk);
   endtask
   task automatic test_disabled;
      wr(data_offset, 32'h0000_1234);
      rchk(data_offset, 32'h0000_0000);
      $display("test disabled done");
   endtask
   task automatic test_event;
      // unit enabled first, then filter; output enable left clear.
      wr(ctrl_offset, 32'h0000_0001);
      wr(ctrl_offset, 32'h0000_0003);
      wr(mode_offset, 32'h0000_0004);
      wr(data_offset, 32'h0000_0002);
      repeat (4) @(posedge i_clk);
      wr(trigger_offset, 32'h0000_0001);
      rchk(count_offset, 32'h0000_0002);
      rchk(status_offset, 32'h0000_0002);
      rchk(trigger_offset, 32'h0000_0000);
      rchk(8'h18, 32'h0000_0000);
      pulses(2);
      rchk(count_offset, 32'h0000_0000);
      chk(irqs, 0);
      // only the data register is rewritten while running.
      wr(data_offset, 32'h0000_0000);
      pulses(1);
      chk(irqs, 1);
      rchk(count_offset, 32'h0000_0000);
      pulses(2);
      chk(irqs, 3);
      wr(trigger_offset, 32'h0000_0002);
      rchk(status_offset, 32'h0000_0000);
      pulses(1);
      chk(irqs, 3);
      chk(tout, 1'b0);
      $display("test event done");
   endtask
   task automatic test_capture;
      wr(ctrl_offset, 32'h0000_0000);
      rchk(count_offset, 32'h0000_0000);
      wr(ctrl_offset, 32'h0000_0001);
      // Output enabled before start, so each interrupt toggles the pin.
      wr(ctrl_offset, 32'h0000_0005);
      // capture mode, start interrupt, rising edges, source 001.
      // the mode is not touched again while capturing.
      wr(mode_offset, 32'h0000_0017);
      repeat (2) @(posedge i_clk);
      wr(trigger_offset, 32'h0000_0001);
      repeat (4) @(posedge i_clk);
      chk(irqs, 4);
      wr(trigger_offset, 32'h0000_0001);
      repeat (65544) @(posedge i_clk);
      wr(trigger_offset, 32'h0000_0001);
      rchk(data_offset, 32'h0000_0009);
      rchk(status_offset, 32'h0000_0003);
      wr(trigger_offset, 32'h0000_0002);
      rchk(status_offset, 32'h0000_0001);
      wr(trigger_offset, 32'h0000_0001);
      wr(trigger_offset, 32'h0000_0001);
      repeat (18) @(posedge i_clk);
      wr(trigger_offset, 32'h0000_0001);
      rchk(data_offset, 32'h0000_0013);
      rchk(status_offset, 32'h0000_0002);
      pulses(1);
      chk(irqs, 10);
      chk(tout, 1'b1);
      $display("test capture done");
   endtask
   // Reset, then the scenarios in turn.
   initial begin
      i_reset = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      req = 1'b0;
      i_addr = 8'h00;
      npulse = 8'h00;
      i_wdata = 32'h0000_0000;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      test_disabled();
      test_event();
      test_capture();
      conclude();
   end
endmodule
